// >>> wsl_core.sv
/*
  Digital control of a 256-step potentiometer: serial shift-in and wiper load.
  Assumes the SPI pins are asynchronous and far slower than clk (link clock about 800 ns).
*/
// Notes on behaviour
// - An 8-bit wiper register selects exactly one of 256 taps.
// - Code 0x00 connects wiper to B; higher codes move away from B.
// - Code D selects tap D steps from B; top segment never reached.
// - Wiper-to-A resistance largest at zero, falls as code rises.
// - With select low, data shifts in on each rising serial clock.
// - Select rising copies the input register into the wiper register.
// - Extra bits in one frame: only the last eight are kept.
// - At power-up input register clears and wiper presets to 0x80.
// - Every select rising edge transfers, even without new bits.
`timescale 1ns/100ps
`default_nettype none
`include "wsl_map.svh"
module wsl_core
  import wsl_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      reset,
  input  wire logic      sclk,
  input  wire logic      sdi,
  input  wire logic      cs_n,
  output var  wsl_word_t wiper,
  output var  wsl_word_t shift_reg,
  output var  wsl_taps_t tap_sel,
  output var  wsl_word_t rwa_steps
);
  logic      sclk_lvl;
  logic      sclk_rise;
  logic      cs_lvl;
  logic      cs_rise;
  logic      sdi_lvl;
  wsl_word_t next_shift;

  // Idle levels as INIT, so reset makes no false edge
  wsl_pin_sync #(
    .INIT (1'h0)
  ) u_sclk (
    .clk   (clk),
    .reset (reset),
    .pin   (sclk),
    .level (sclk_lvl),
    .rise  (sclk_rise),
    .fall  ()
  );
  wsl_pin_sync #(
    .INIT (1'h1)
  ) u_cs (
    .clk   (clk),
    .reset (reset),
    .pin   (cs_n),
    .level (cs_lvl),
    .rise  (cs_rise),
    .fall  ()
  );
  wsl_pin_sync #(
    .INIT (1'h0)
  ) u_sdi (
    .clk   (clk),
    .reset (reset),
    .pin   (sdi),
    .level (sdi_lvl),
    .rise  (),
    .fall  ()
  );

  // Shift MSB first; oldest bit drops off
  wire shift_en = sclk_rise && !cs_lvl;
  assign next_shift = {shift_reg[`WSL_WORD_W-2:0], sdi_lvl};

  always_ff @(posedge clk) begin
    if (reset) begin
      shift_reg <= `WSL_SIR_RESET;
    end else if (shift_en) begin
      shift_reg <= next_shift;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wiper <= `WSL_WIPER_MID;
    end else if (cs_rise) begin
      wiper <= shift_reg;
    end
  end

  // One-hot tap decode, bit 0 is terminal B
  genvar gi;
  generate
    for (gi = 0; gi < `WSL_TAP_N; gi++) begin : g_tap
      localparam wsl_word_t TAP_CODE = wsl_word_t'(gi);
      assign tap_sel[gi] = (wiper == TAP_CODE);
    end
  endgenerate

  // Steps toward A: 256-D, held as 255-D to fit 8 bits
  assign rwa_steps = ~wiper;

  // Sampled data from a 3-flop chain; sclk edge detected ~300 ns late,
  // but the sdi level used is one clock older, so sdi must be stable before the rising edge.

  logic [3:0] frame_bits;
  wsl_word_t  frame_last;

  always_ff @(posedge clk) begin
    if (reset || cs_lvl) begin
      frame_bits <= 4'h0;
      frame_last <= `WSL_SIR_RESET;
    end else if (shift_en) begin
      frame_bits <= (frame_bits == 4'hF) ? frame_bits : 4'(frame_bits + 4'h1);
      frame_last <= {frame_last[`WSL_WORD_W-2:0], sdi_lvl};
    end
  end

  sequence s_bit_taken;
    sclk_rise && !cs_lvl;
  endsequence

  sequence s_select_rise;
    cs_rise;
  endsequence

  sequence s_frame_end;
    s_select_rise ##1 1'b1;
  endsequence

  property p_power_up;
    @(posedge clk)
      reset |=> wiper == `WSL_WIPER_MID && shift_reg == `WSL_SIR_RESET;
  endproperty
  AST_PWRUP: assert property (p_power_up) else $error("bad power-up value");

  property p_shift;
    @(posedge clk) disable iff (reset)
      s_bit_taken |=> shift_reg == $past(next_shift);
  endproperty
  AST_SHIFT: assert property (p_shift) else $error("shift mismatch");

  property p_no_shift;
    @(posedge clk) disable iff (reset)
      !shift_en |=> $stable(shift_reg);
  endproperty
  AST_NOSHIFT: assert property (p_no_shift) else $error("shift without clock edge");

  property p_last8;
    @(posedge clk) disable iff (reset)
      s_bit_taken |=> shift_reg[`WSL_WORD_W-1:1] == $past(shift_reg[`WSL_WORD_W-2:0]);
  endproperty
  AST_LAST8: assert property (p_last8) else $error("excess bits kept");

  property p_frame_last8;
    @(posedge clk) disable iff (reset)
      cs_rise && frame_bits >= 4'h8 |=> wiper == $past(frame_last);
  endproperty
  AST_FRAME8: assert property (p_frame_last8) else $error("wiper not last eight bits");

  property p_hold;
    @(posedge clk) disable iff (reset)
      cs_lvl && !cs_rise |=> $stable(shift_reg) && $stable(wiper);
  endproperty
  AST_HOLD: assert property (p_hold) else $error("change while deselected");

  property p_ignore;
    @(posedge clk) disable iff (reset)
      sclk_rise && cs_lvl |=> $stable(shift_reg);
  endproperty
  AST_IGNORE: assert property (p_ignore) else $error("clock edge taken while deselected");

  property p_load;
    @(posedge clk) disable iff (reset)
      s_select_rise |=> wiper == $past(shift_reg);
  endproperty
  AST_LOAD: assert property (p_load) else $error("wiper not loaded");

  property p_no_load;
    @(posedge clk) disable iff (reset)
      !cs_rise |=> $stable(wiper);
  endproperty
  AST_NOLOAD: assert property (p_no_load) else $error("wiper changed without select rise");

  property p_reload;
    @(posedge clk) disable iff (reset)
      s_frame_end |-> wiper == shift_reg || $past(shift_en);
  endproperty
  AST_RELOAD: assert property (p_reload) else $error("transfer skipped");

  property p_one_tap;
    @(posedge clk) disable iff (reset)
      $onehot(tap_sel) && tap_sel[wiper];
  endproperty
  AST_ONEHOT: assert property (p_one_tap) else $error("tap decode not one-hot");

  property p_zero_b;
    @(posedge clk) disable iff (reset)
      wiper == 8'h00 |-> tap_sel[0];
  endproperty
  AST_ZERO_B: assert property (p_zero_b) else $error("zero code not at B");

  property p_tap_steps;
    @(posedge clk) disable iff (reset)
      tap_sel == (wsl_taps_t'(1'h1) << wiper);
  endproperty
  AST_TAP_D: assert property (p_tap_steps) else $error("tap not D steps from B");

  property p_rwa;
    @(posedge clk) disable iff (reset)
      wiper > $past(wiper) |-> rwa_steps < $past(rwa_steps);
  endproperty
  AST_RWA: assert property (p_rwa) else $error("A side not falling");

  property p_rwa_sum;
    @(posedge clk) disable iff (reset)
      wsl_word_t'(wiper + rwa_steps) == 8'hFF;
  endproperty
  AST_RWA_SUM: assert property (p_rwa_sum) else $error("A and B steps do not complement");
endmodule : wsl_core
`default_nettype wire

// >>> wsl_core_tb.sv
/* Self-checking bench for the wiper serial loader.
   Assumes wsl_master as far side and a 10 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
module wsl_core_tb
  import wsl_pkg::*;
();
  logic      clk = 1'b0;
  logic      reset = 1'b1;
  wire logic sclk, sdi, cs_n;
  wsl_word_t wiper, shift_reg, rwa_steps;
  wsl_taps_t tap_sel;
  int        num_errors = 0;
  int        num_checks = 0;
  always #50 clk = ~clk;
  wsl_master PM (.clk(clk), .sclk(sclk), .sdi(sdi), .cs_n(cs_n));
  wsl_core DUT (.clk(clk), .reset(reset), .sclk(sclk), .sdi(sdi), .cs_n(cs_n),
    .wiper(wiper), .shift_reg(shift_reg), .tap_sel(tap_sel), .rwa_steps(rwa_steps));
  task automatic chk(input string what, input logic [255:0] exp, input logic [255:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic look(input logic [7:0] s, input logic [7:0] w);
    chk("shift_reg", s, shift_reg);
    chk("wiper", w, wiper);
    chk("tap_sel", 256'h1 << w, tap_sel);
    chk("rwa_steps", 8'hFF - w, rwa_steps);
  endtask : look
  task automatic t_power;
    look(8'h00, 8'h80);
    $display("t_power done");
  endtask : t_power
  task automatic t_toggle;
    PM.frame(16'h0000, 0, 1'b1);
    look(8'h00, 8'h00);
    $display("t_toggle done");
  endtask : t_toggle
  task automatic t_words;
    logic [7:0] codes [3] = '{8'hA5, 8'h01, 8'hFF};
    foreach (codes[i]) begin
      PM.frame({8'h00, codes[i]}, 8, 1'b1);
      look(codes[i], codes[i]);
    end
    $display("t_words done");
  endtask : t_words
  task automatic t_extra;
    PM.frame(16'h0F3C, 12, 1'b1);
    look(8'h3C, 8'h3C);
    $display("t_extra done");
  endtask : t_extra
  task automatic t_ignore;
    PM.frame(16'h00C3, 8, 1'b0);
    look(8'h3C, 8'h3C);
    $display("t_ignore done");
  endtask : t_ignore
  task automatic t_reset;
    reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    look(8'h00, 8'h80);
    $display("t_reset done");
  endtask : t_reset
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    t_power();
    t_toggle();
    t_words();
    t_extra();
    t_ignore();
    t_reset();
    summarize();
  end
  // Frames take under 100 us in all
  initial begin
    #300000;
    num_errors++;
    summarize();
  end
endmodule : wsl_core_tb
`default_nettype wire

// >>> wsl_map.svh
/*
  Constants for the wiper serial loader: widths, power-up values and synchroniser depth.
  Assumes inclusion by the package and the design modules; definitions only.
*/
`ifndef WSL_MAP_SVH
`define WSL_MAP_SVH
`define WSL_WORD_W     8
`define WSL_TAP_N      256
`define WSL_SIR_RESET  8'h00
`define WSL_WIPER_MID  8'h80
`define WSL_SYNC_W     3
`endif

// >>> wsl_master.sv
/* SPI master model that sends write-only frames.
   Assumes the bench clock; pins change at its falling edge. */
`timescale 1ns/100ps
`default_nettype none
module wsl_master (
  input  wire logic clk,
  output var  logic sclk,
  output var  logic sdi,
  output var  logic cs_n
);
  initial begin
    sclk = 1'b0;
    sdi  = 1'b0;
    cs_n = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk
  task automatic frame(input logic [15:0] d, input int n, input logic sel);
    cs_n = ~sel;
    wait_clk(4);
    for (int i = n - 1; i >= 0; i--) begin
      sdi = d[i];
      wait_clk(4);
      sclk = 1'b1;
      wait_clk(4);
      sclk = 1'b0;
    end
    wait_clk(4);
    cs_n = 1'b1;
    // Released line shows no stale bit
    sdi = ~sdi;
    wait_clk(8);
  endtask : frame
endmodule : wsl_master
`default_nettype wire

// >>> wsl_pin_sync.sv
/*
  Three-flop pin synchroniser with agreement filter and edge pulses.
  Assumes an asynchronous pin input and the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "wsl_map.svh"
module wsl_pin_sync
  import wsl_pkg::*;
#(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic pin,
  output var  logic level,
  output var  logic rise,
  output var  logic fall
);
  logic [`WSL_SYNC_W-1:0] sync;
  wire                    agree = (sync[1] == sync[2]);

  always_ff @(posedge clk) begin
    if (reset) begin
      sync  <= {`WSL_SYNC_W{INIT}};
      level <= INIT;
    end else begin
      sync <= {sync[1:0], pin};
      if (agree) begin
        level <= sync[2];
      end
    end
  end

  // Pulses follow the filtered level; only stable samples count
  assign rise = agree && sync[2] && !level;
  assign fall = agree && !sync[2] && level;
endmodule : wsl_pin_sync
`default_nettype wire

// >>> wsl_pkg.sv
/*
  Types for the wiper serial loader.
  Assumes wsl_map.svh is reachable by bare name.
*/
`include "wsl_map.svh"
package wsl_pkg;
  typedef logic [`WSL_WORD_W-1:0] wsl_word_t;
  typedef logic [`WSL_TAP_N-1:0]  wsl_taps_t;
endpackage : wsl_pkg
